// file: common/sqq_cfg.svh
// Purpose: constants for the switch query and quiesce message handler
// Assumes: messages arrive byte-wide, first byte first, one frame at a time
// Notes: none
`ifndef SQQ_CFG_SVH
`define SQQ_CFG_SVH
`define SQQ_CODE_QSW 8'h0c
`define SQQ_CODE_QSW_REPLY 8'h0d
`define SQQ_CODE_QUIESCE 8'h06
`define SQQ_CODE_RESPONSE 8'h01
`define SQQ_RC_OK 8'h00
`define SQQ_RC_NO_ENTRY 8'h01
`define SQQ_RCTE_BIT 7
`define SQQ_QSW_LEN 5'd8
`define SQQ_QSW_REPLY_LEN 5'd20
`define SQQ_QUI_LEN 5'd16
`define SQQ_RESP_LEN 5'd8
`define SQQ_MASK_LAST 5'd19
`define SQQ_MASK_RSVD 8'hfc
`define SQQ_TBL_DEPTH 8
`define SQQ_NPORTS 126
`endif

// file: common/sqq_pkg.sv
// Purpose: types shared by the switch query and quiesce handler and its bench
// Assumes: byte-wide message stream, eight-entry initiator table
// Notes: table entry keeps its identity while reserved so a later quiesce still finds it
package sqq_pkg;
    typedef enum logic [2:0] {
        SQQ_IDLE = 3'b000,
        SQQ_RECV = 3'b001,
        SQQ_ABORT = 3'b010,
        SQQ_TABLE = 3'b011,
        SQQ_NOTIFY = 3'b100,
        SQQ_SEND = 3'b101,
        SQQ_DROP = 3'b110
    } sqq_state_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } sqq_byte_t;
    typedef struct packed {
        logic valid;
        logic keep;
        logic [63:0] identity;
        logic [31:0] path;
    } sqq_entry_t;
endpackage

// file: src/sqq_handler.sv
// Purpose: answers switch queries and carries out quiesce requests
// Assumes: rx bytes are synchronous; tx sink always accepts a byte
// Notes: table writes from registration logic are outside this block
`include "sqq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sqq_handler
    import sqq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire sqq_byte_t rx,
    input wire logic [6:0] rx_port,
    input wire logic [125:0] port_oper,
    input wire logic tbl_load,
    input wire logic [2:0] tbl_load_idx,
    input wire sqq_entry_t tbl_load_entry,
    output sqq_byte_t tx,
    output logic [6:0] tx_port,
    output logic [7:0] abort_path_valid,
    output logic [31:0] abort_path,
    output logic abort_strobe,
    output logic ulp_event,
    output logic [63:0] ulp_identity,
    output logic [7:0] tbl_valid,
    output logic [7:0] tbl_keep
);
    sqq_state_t state_r;
    logic [4:0] cnt_r;
    logic [7:0] code_r;
    logic [7:0] flags_r;
    logic [15:0] tag_r;
    logic [31:0] rpath_r;
    logic [63:0] ident_r;
    logic [6:0] port_r;
    logic [2:0] scan_r;
    logic found_r;
    logic kept_r;
    logic [7:0] hit_r;
    sqq_entry_t tbl_r [`SQQ_TBL_DEPTH];
    logic [4:0] out_len;
    logic [7:0] out_byte;
    logic [7:0] mask_byte;
    logic [127:0] mask_vec;
    logic is_qsw;

    assign is_qsw = (code_r == `SQQ_CODE_QSW);
    // port 1 lands in vector msb so byte slicing walks ports upward
    always_comb begin
        mask_vec = '0;
        for (int i = 0; i < `SQQ_NPORTS; i++) begin
            mask_vec[127 - i] = port_oper[i];
        end
        mask_byte = mask_vec[8'(127 - 8 * (cnt_r - 5'd4)) -: 8];
        if (cnt_r == `SQQ_MASK_LAST) begin
            mask_byte = mask_byte & `SQQ_MASK_RSVD;
        end
    end

    always_comb begin
        out_len = is_qsw ? `SQQ_QSW_REPLY_LEN : `SQQ_RESP_LEN;
        out_byte = 8'h00;
        unique case (cnt_r)
            5'd0: out_byte = is_qsw ? `SQQ_CODE_QSW_REPLY : `SQQ_CODE_RESPONSE;
            5'd1: out_byte = is_qsw ? {1'b0, port_r} : 8'h00;
            5'd2: out_byte = tag_r[15:8];
            5'd3: out_byte = tag_r[7:0];
            default: begin
                if (is_qsw) begin
                    out_byte = mask_byte;
                end else if (cnt_r < 5'd7) begin
                    out_byte = rpath_r[8'(31 - 8 * (cnt_r - 5'd4)) -: 8];
                end else begin
                    out_byte = found_r ? `SQQ_RC_OK : `SQQ_RC_NO_ENTRY;
                end
            end
        endcase
    end

    // message capture and sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= SQQ_IDLE;
            cnt_r <= 5'd0;
            code_r <= 8'h00;
            flags_r <= 8'h00;
            tag_r <= 16'h0000;
            rpath_r <= 32'h0000_0000;
            ident_r <= 64'h0;
            port_r <= 7'h00;
            scan_r <= 3'd0;
        end else begin
            unique case (state_r)
                SQQ_IDLE: if (rx.valid) begin
                    code_r <= rx.data;
                    port_r <= rx_port;
                    cnt_r <= 5'd1;
                    if (rx.data == `SQQ_CODE_QSW || rx.data == `SQQ_CODE_QUIESCE) begin
                        state_r <= rx.last ? SQQ_IDLE : SQQ_RECV;
                    end else begin
                        state_r <= rx.last ? SQQ_IDLE : SQQ_DROP;
                    end
                end
                SQQ_RECV: if (rx.valid) begin
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == 5'd1) flags_r <= rx.data;
                    if (cnt_r == 5'd2 || cnt_r == 5'd3) tag_r <= {tag_r[7:0], rx.data};
                    if (cnt_r >= 5'd4 && cnt_r < 5'd8) rpath_r <= {rpath_r[23:0], rx.data};
                    if (cnt_r >= 5'd8) ident_r <= {ident_r[55:0], rx.data};
                    if (rx.last) begin
                        cnt_r <= 5'd0;
                        scan_r <= 3'd0;
                        if (is_qsw && cnt_r == `SQQ_QSW_LEN - 5'd1) begin
                            state_r <= SQQ_SEND;
                        end else if (!is_qsw && cnt_r == `SQQ_QUI_LEN - 5'd1) begin
                            state_r <= SQQ_ABORT;
                        end else begin
                            state_r <= SQQ_IDLE;
                        end
                    end
                end
                SQQ_ABORT: begin
                    scan_r <= scan_r + 3'd1;
                    if (scan_r == 3'(`SQQ_TBL_DEPTH - 1)) state_r <= SQQ_TABLE;
                end
                SQQ_TABLE: state_r <= SQQ_NOTIFY;
                SQQ_NOTIFY: state_r <= SQQ_SEND;
                SQQ_SEND: begin
                    cnt_r <= cnt_r + 5'd1;
                    if (cnt_r == out_len - 5'd1) begin
                        cnt_r <= 5'd0;
                        state_r <= SQQ_IDLE;
                    end
                end
                SQQ_DROP: if (rx.valid && rx.last) state_r <= SQQ_IDLE;
                default: state_r <= SQQ_IDLE;
            endcase
        end
    end

    // table lookup and abort of every valid matching return path
    always_ff @(posedge clk) begin
        if (reset) begin
            abort_strobe <= 1'b0;
            abort_path <= 32'h0000_0000;
            abort_path_valid <= 8'h00;
            found_r <= 1'b0;
            hit_r <= 8'h00;
        end else begin
            abort_strobe <= 1'b0;
            abort_path_valid <= 8'h00;
            if (state_r == SQQ_RECV && rx.valid && rx.last) begin
                found_r <= 1'b0;
                hit_r <= 8'h00;
            end
            // reserved entries count as hits so a flagged quiesce frees them too
            if (state_r == SQQ_ABORT && (tbl_r[scan_r].valid || tbl_r[scan_r].keep) &&
                tbl_r[scan_r].identity == ident_r) begin
                found_r <= 1'b1;
                hit_r[scan_r] <= 1'b1;
                if (tbl_r[scan_r].valid) begin
                    abort_strobe <= 1'b1;
                    abort_path <= tbl_r[scan_r].path;
                    abort_path_valid[scan_r] <= 1'b1;
                end
            end
        end
    end

    // table entry update after all aborts issued
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < `SQQ_TBL_DEPTH; i++) tbl_r[i] <= '0;
            kept_r <= 1'b0;
        end else if (state_r == SQQ_TABLE) begin
            kept_r <= 1'b0;
            for (int i = 0; i < `SQQ_TBL_DEPTH; i++) begin
                if (hit_r[i]) begin
                    tbl_r[i].valid <= 1'b0;
                    // the first hit stays reserved unless the RCTE flag is set, so re-registration has a slot
                    tbl_r[i].keep <= !flags_r[`SQQ_RCTE_BIT] && hit_r[i] &&
                        ((8'(hit_r << (8 - i)) == 8'h00) || i == 0);
                end
            end
        end else if (tbl_load) begin
            tbl_r[tbl_load_idx] <= tbl_load_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ulp_event <= 1'b0;
            ulp_identity <= 64'h0;
        end else begin
            ulp_event <= (state_r == SQQ_NOTIFY);
            if (state_r == SQQ_NOTIFY) ulp_identity <= ident_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx <= '0;
            tx_port <= 7'h00;
        end else begin
            tx.valid <= (state_r == SQQ_SEND);
            tx.data <= (state_r == SQQ_SEND) ? out_byte : 8'h00;
            tx.last <= (state_r == SQQ_SEND) && (cnt_r == out_len - 5'd1);
            tx_port <= port_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tbl_valid <= 8'h00;
            tbl_keep <= 8'h00;
        end else begin
            for (int i = 0; i < `SQQ_TBL_DEPTH; i++) begin
                tbl_valid[i] <= tbl_r[i].valid;
                tbl_keep[i] <= tbl_r[i].keep;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/sqq_far_node.sv
// Purpose: configuring node sending messages to the handler
// Assumes: caller builds whole, well formed messages
// Notes: data line shows the inverse of the last byte when idle after a message, and zero before the first
`timescale 1ns/1ps
`default_nettype none
module sqq_far_node
    import sqq_pkg::*;
(
    input wire logic clk,
    output var sqq_byte_t rx,
    output var logic [6:0] rx_port
);
    initial begin
        rx = '0;
        rx_port = 7'h00;
    end
    // code, tag and flag policy come from the caller
    task automatic send(input logic [7:0] m[$], input logic [6:0] p);
        for (int i = 0; i < m.size(); i++) begin
            @(posedge clk);
            rx <= '{1'b1, m[i], i == m.size() - 1};
            rx_port <= p;
        end
        @(posedge clk);
        rx <= '{1'b0, ~m[m.size() - 1], 1'b0};
    endtask
endmodule
`default_nettype wire

// file: verification/sqq_handler_assertions.sv
// Purpose: port checks for sqq_handler
// Assumes: one message in flight at a time
// Notes: helpers track the head of the last message
`timescale 1ns/1ps
`default_nettype none
module sqq_handler_chk
    import sqq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire sqq_byte_t rx,
    input wire logic [6:0] rx_port,
    input wire sqq_byte_t tx,
    input wire logic [6:0] tx_port,
    input wire logic [7:0] abort_path_valid,
    input wire logic abort_strobe,
    input wire logic ulp_event
);
    logic first_r;
    logic seen_ulp_r;
    logic [7:0] code_r;
    logic [6:0] port_r;
    logic [4:0] cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) begin
        if (reset) begin
            first_r <= 1'b1;
            code_r <= 8'h00;
            port_r <= 7'h00;
            cnt_r <= 5'h00;
        end else if (rx.valid) begin
            first_r <= rx.last;
            code_r <= first_r ? rx.data : code_r;
            port_r <= first_r ? rx_port : port_r;
            cnt_r <= first_r ? 5'h01 : cnt_r + 5'h01;
        end
    end
    // set by the notify pulse, dropped once the response is on its way
    always_ff @(posedge clk) begin
        seen_ulp_r <= !reset && (ulp_event || (seen_ulp_r && !tx.valid));
    end
    chk_reply_code: assert property ($rose(tx.valid) && code_r == 8'h0c |-> tx.data == 8'h0d)
        else $error("reply code wrong");
    chk_reply_start: assert property (rx.valid && rx.last && cnt_r == 5'h07 && code_r == 8'h0c
        |-> ##[1:3] tx.valid)
        else $error("reply late");
    chk_reply_port: assert property (tx.valid |-> tx_port == port_r)
        else $error("reply port wrong");
    chk_port_field: assert property ($rose(tx.valid) && code_r == 8'h0c
        |=> tx.data == {1'b0, port_r})
        else $error("port byte wrong");
    chk_mask_rsvd: assert property (tx.valid && tx.last && code_r == 8'h0c |-> tx.data[1:0] == 2'b00)
        else $error("reserved bits set");
    chk_notify_first: assert property ($rose(tx.valid) && code_r == 8'h06 |-> seen_ulp_r)
        else $error("response before notify");
    chk_resp_code: assert property ($rose(tx.valid) && code_r == 8'h06 |-> tx.data == 8'h01)
        else $error("response code wrong");
    chk_ulp_pulse: assert property (ulp_event |=> !ulp_event)
        else $error("notify too long");
    chk_abort_slot: assert property (abort_strobe |-> $onehot(abort_path_valid) && !tx.valid)
        else $error("abort slot wrong");
endmodule
bind sqq_handler sqq_handler_chk u_chk (.clk, .reset, .rx, .rx_port, .tx, .tx_port,
    .abort_path_valid, .abort_strobe, .ulp_event);
`default_nettype wire

// file: verification/testbench.sv
// Purpose: scenario bench for sqq_handler
// Assumes: tx sink always ready
// Notes: table preloaded through the load port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sqq_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [125:0] port_oper = '0;
    logic tbl_load = 1'b0;
    logic [2:0] tbl_load_idx = 3'h0;
    sqq_entry_t tbl_load_entry = '0;
    sqq_byte_t rx;
    sqq_byte_t tx;
    logic [6:0] rx_port;
    logic [6:0] tx_port;
    logic [7:0] abort_path_valid;
    logic [31:0] abort_path;
    logic abort_strobe;
    logic ulp_event;
    logic [63:0] ulp_identity;
    logic [7:0] tbl_valid;
    logic [7:0] tbl_keep;
    logic [7:0] got[$];
    int n_abort;
    int n_last;
    logic [7:0] slots;
    logic [31:0] psum;
    int num_errors = 0;
    int checked = 0;
    always #20 clk = ~clk;
    sqq_far_node far (.clk(clk), .rx(rx), .rx_port(rx_port));
    sqq_handler dut (.clk(clk), .reset(reset), .rx(rx), .rx_port(rx_port),
        .port_oper(port_oper), .tbl_load(tbl_load), .tbl_load_idx(tbl_load_idx),
        .tbl_load_entry(tbl_load_entry), .tx(tx), .tx_port(tx_port),
        .abort_path_valid(abort_path_valid), .abort_path(abort_path),
        .abort_strobe(abort_strobe), .ulp_event(ulp_event), .ulp_identity(ulp_identity),
        .tbl_valid(tbl_valid), .tbl_keep(tbl_keep));
    always @(posedge clk) begin
        if (tx.valid) got.push_back(tx.data);
        if (tx.valid && tx.last) n_last = got.size();
        if (abort_strobe) begin
            n_abort++;
            slots |= abort_path_valid;
            psum ^= abort_path;
        end
    end
    task automatic wrap_up();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_tx(int n);
        for (int i = 0; i < 300 && got.size() < n; i++) @(negedge clk);
        check("tx bytes", got.size(), n);
    endtask
    task automatic t_query(logic [6:0] p, logic [15:0] tag, logic [125:0] ops);
        logic [7:0] e;
        @(posedge clk);
        port_oper <= ops;
        got = {};
        n_last = 0;
        far.send('{8'h0c, 8'h00, tag[15:8], tag[7:0], 8'h11, 8'h22, 8'h33, 8'h44}, p);
        wait_tx(20);
        check("last", n_last, 20);
        check("tx port", tx_port, p);
        check("code", got[0], 8'h0d);
        check("port", got[1], {1'b0, p});
        check("tag", {got[2], got[3]}, tag);
        for (int k = 0; k < 16; k++) begin
            for (int b = 0; b < 8; b++) e[7 - b] = (k * 8 + b < 126) ? ops[k * 8 + b] : 1'b0;
            check("mask", got[4 + k], e);
        end
    endtask
    task automatic load(logic [2:0] i, logic [63:0] id, logic [31:0] pth);
        @(posedge clk);
        tbl_load <= 1'b1;
        tbl_load_idx <= i;
        tbl_load_entry <= '{1'b1, 1'b0, id, pth};
        @(posedge clk);
        tbl_load <= 1'b0;
    endtask
    task automatic t_quiesce(logic rcte, logic [63:0] id, logic [31:0] pth, logic [15:0] tag,
        logic [7:0] rc, int aborts, logic [7:0] ev, logic [7:0] ek, logic [7:0] es,
        logic [31:0] ep);
        logic [7:0] m[$];
        m = {8'h06, 8'({rcte, 7'h00}), tag[15:8], tag[7:0]};
        for (int i = 3; i >= 0; i--) m.push_back(pth[i * 8 +: 8]);
        for (int i = 7; i >= 0; i--) m.push_back(id[i * 8 +: 8]);
        got = {};
        n_last = 0;
        n_abort = 0;
        slots = 8'h00;
        psum = 32'h0000_0000;
        far.send(m, 7'd2);
        wait_tx(8);
        check("resp last", n_last, 8);
        check("resp code", got[0], 8'h01);
        check("resp byte1", got[1], 8'h00);
        check("resp tag", {got[2], got[3]}, tag);
        check("resp path", {got[4], got[5], got[6]}, pth[31:8]);
        check("resp rc", got[7], rc);
        check("aborts", n_abort, aborts);
        check("abort slots", slots, es);
        check("abort paths", psum, ep);
        if (aborts > 0) check("ulp id", ulp_identity, id);
        check("tbl valid", tbl_valid, ev);
        check("tbl keep", tbl_keep, ek);
    endtask
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check("idle tx", tx.valid, 1'b0);
        check("idle tbl", tbl_valid, 8'h00);
        t_query(7'd5, 16'hbeef, {126{1'b1}});
        t_query(7'd126, 16'h0102, {63{2'b10}});
        got = {};
        far.send('{8'h0c, 8'h00, 8'h01}, 7'd1);
        repeat (40) @(negedge clk);
        check("dropped", got.size(), 0);
        load(3'd0, 64'ha1, 32'h0a0b0c0d);
        load(3'd1, 64'ha1, 32'h0e0f1011);
        load(3'd2, 64'hb2, 32'h12131415);
        t_quiesce(1'b0, 64'ha1, 32'h0a0b0c0d, 16'h0011, 8'h00, 2, 8'h04, 8'h01, 8'h03,
            32'h0a0b0c0d ^ 32'h0e0f1011);
        t_quiesce(1'b1, 64'hb2, 32'h12131415, 16'h0012, 8'h00, 1, 8'h00, 8'h01, 8'h04,
            32'h12131415);
        t_quiesce(1'b1, 64'hc3, 32'h21222324, 16'h0013, 8'h01, 0, 8'h00, 8'h01, 8'h00,
            32'h0000_0000);
        // flagged quiesce must also free the entry reserved earlier for this identity
        t_quiesce(1'b1, 64'ha1, 32'h31323334, 16'h0014, 8'h00, 0, 8'h00, 8'h00, 8'h00,
            32'h0000_0000);
        wrap_up();
    end
endmodule
`default_nettype wire
